// File: logic/alc_pkg.sv
package alc_pkg;

  localparam int CLK_NS      = 20;
  localparam int CLK_HZ_DEF  = 50_000_000;
  localparam int STRETCH_NS  = 400;
  localparam int STRETCH_CYC = (STRETCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLRM_NS     = 75;
  localparam int CLRM_CYC    = (CLRM_NS + CLK_NS - 1) / CLK_NS;
  localparam int ONESHOT_NS  = 1000;
  localparam int ONESHOT_CYC = (ONESHOT_NS + CLK_NS - 1) / CLK_NS;

  // Control word field positions
  localparam int LCW_SEL_LSB   = 9;
  localparam int LCW_DATA_LSB  = 11;
  localparam int LCW_MAINT_BIT = 11;
  // Receiver-on lives in primary bit 2 (control word bit 13)
  localparam int PRI_RXON_BIT  = 2;

  localparam logic [1:0] SEL_PRIMARY = 2'h0;
  localparam logic [1:0] SEL_FORMAT  = 2'h1;
  localparam logic [1:0] SEL_BAUD    = 2'h2;
  localparam logic [1:0] SEL_MAINT   = 2'h3;

  localparam logic [3:0] PRIMARY_RST = 4'h0;
  localparam logic [3:0] FORMAT_RST  = 4'h0;
  localparam logic [3:0] BAUD_RST    = 4'h0;
  localparam logic       MAINT_RST   = 1'b0;

  // Code 17 octal selects the fast crystal-derived rate
  localparam logic [3:0] FAST_CODE   = 4'hF;
  localparam int         FAST_RATE10 = 384000;

  localparam int FIFO_W = 12;
  localparam int FIFO_D = 16;

  // Error field: 1 parity, 2 overrun, 3 framing
  localparam logic [1:0] ERR_NONE    = 2'h0;
  localparam logic [1:0] ERR_PARITY  = 2'h1;
  localparam logic [1:0] ERR_OVERRUN = 2'h2;
  localparam logic [1:0] ERR_FRAMING = 2'h3;

  typedef enum logic [0:0] {STB_IDLE = 1'b0, STB_HOLD = 1'b1} alc_stb_t;

  function automatic logic [1:0] alc_err_code(input logic fe, input logic pe, input logic oe);
    if (oe)      return ERR_OVERRUN;
    else if (fe) return ERR_FRAMING;
    else if (pe) return ERR_PARITY;
    else         return ERR_NONE;
  endfunction

  // Baud rate times ten, per 4-bit select code
  function automatic int alc_rate10(input int code);
    case (code)
      0: return 500;      1: return 750;      2: return 1100;    3: return 1345;
      4: return 1500;     5: return 3000;     6: return 6000;    7: return 12000;
      8: return 18000;    9: return 20000;    10: return 24000;  11: return 36000;
      12: return 48000;   13: return 72000;   14: return 96000;
      default: return 192000;
    endcase
  endfunction

  // Clock cycles per 16x bit-clock tick
  function automatic logic [15:0] alc_div(input int clk_hz, input int rate10);
    return 16'((clk_hz / 16) * 10 / rate10);
  endfunction

  function automatic logic [255:0] alc_div_table(input int clk_hz);
    logic [255:0] t;
    t = '0;
    for (int i = 0; i < 16; i++) begin
      t[i*16 +: 16] = alc_div(clk_hz, alc_rate10(i));
    end
    return t;
  endfunction

endpackage

// File: logic/alc_fifo.sv
`timescale 1ns/1ps
module alc_fifo #(
  parameter int W = 12,
  parameter int D = 16
) (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);

  logic [D-1:0][W-1:0] mem_r, mem_nxt;
  logic [AW-1:0]       wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]         cnt_r, cnt_nxt;
  logic                push, pop;

  always_comb begin
    push    = in_valid_i & in_ready_o;
    pop     = out_valid_o & out_ready_i;
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data_i;
      wp_nxt        = wp_r + AW'(1);
    end
    if (pop) begin
      rp_nxt = rp_r + AW'(1);
    end
    if (push & ~pop) cnt_nxt = cnt_r + (AW+1)'(1);
    else if (pop & ~push) cnt_nxt = cnt_r - (AW+1)'(1);
  end

  assign in_ready_o  = (cnt_r != (AW+1)'(D));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rp_r];

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem_r <= '0;
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// File: logic/alc_baud_gen.sv
`timescale 1ns/1ps
module alc_baud_gen #(
  parameter int CLK_HZ = 50_000_000
) (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  input  wire logic [3:0] code_i,
  input  wire logic       fast_i,
  output logic            tick_o
);
  import alc_pkg::*;

  localparam logic [255:0] DIV_TAB  = alc_div_table(CLK_HZ);
  localparam logic [15:0]  FAST_DIV = alc_div(CLK_HZ, FAST_RATE10);

  logic [15:0] cnt_r, cnt_nxt, lim;
  logic        tick_nxt;

  always_comb begin
    lim      = fast_i ? FAST_DIV : DIV_TAB[{code_i, 4'h0} +: 16];
    cnt_nxt  = cnt_r + 16'h0001;
    tick_nxt = 1'b0;
    // Restart also when a new code shrinks the limit below the count
    if (cnt_r + 16'h0001 >= lim) begin
      cnt_nxt  = 16'h0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r  <= 16'h0000;
      tick_o <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_o <= tick_nxt;
    end
  end
endmodule

// File: logic/alc_card.sv
`timescale 1ns/1ps
// Summary of operation
// - Format register selects bits, stop, parity
// - Select high bits pick card, low line
// - Control bits 10:9 pick target register
// - Stretch strobe, steer to one of 16
// - Primary register takes control bits 11-14
// - Maintenance bit loads from control bit 11
// - Init clears primary and maintenance, keeps format and baud
// - Scan bits pick card, line and side
// - Transmit-waiting low when scanned entry empty
// - Receiver flag low on pending or match
// - Receiver-on edge one-shot sets match flag
// - Match sets active, drives match detect
// - Inactive line cannot show receive pending
// - Read strobe clears match or pending
// - Resync clears match and active flags
// - Entry holds eight data, 2-bit error
// - Drive data only on select and enable
// - Pending set on load, cleared on read
// - Generator gives 50-9600 baud per line
// - Code 17 sets speed flag, 38.4K
// - One common bit clock per line
module alc_card #(
  parameter logic [1:0] CARD_ID = 2'h0,
  parameter int         CLK_HZ  = alc_pkg::CLK_HZ_DEF
) (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        mux_init_i,
  input  wire logic [3:0]  line_select_register_i,
  input  wire logic [15:0] line_control_word_i,
  input  wire logic        ctrl_strobe_i,
  input  wire logic [3:0]  scan_i,
  input  wire logic        scan_tx_i,
  input  wire logic        tx_strobe_i,
  input  wire logic [7:0]  tx_char_i,
  input  wire logic        received_char_strobe_i,
  input  wire logic [3:0]  resync_i,
  input  wire logic        card_flag_sel_i,
  input  wire logic        data_enable_i,
  input  wire logic [3:0]  rx_avail_i,
  input  wire logic [31:0] rx_char_i,
  input  wire logic [3:0]  rx_framing_fault_i,
  input  wire logic [3:0]  rx_parity_fault_i,
  input  wire logic [3:0]  rx_overrun_i,
  input  wire logic [3:0]  tx_empty_i,
  output logic [3:0]       rx_take_o,
  output logic [3:0]       tx_load_o,
  output logic [7:0]       tx_data_o,
  output logic             tx_wait_n_o,
  output logic             rx_flag_n_o,
  output logic             match_det_n_o,
  output logic [9:0]       rx_bus_o,
  output logic             rx_bus_oe_o,
  output logic [15:0]      primary_o,
  output logic [15:0]      format_o,
  output logic [3:0]       format_strobe_o,
  output logic [15:0]      baud_sel_o,
  output logic [3:0]       baud_select_strobe_o,
  output logic [3:0]       maint_o,
  output logic [3:0]       speed_o,
  output logic [3:0]       line_clk_o
);
  import alc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Shared decode

  function automatic logic [3:0] low_onehot(input logic [3:0] req);
    logic [3:0] g;
    g = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      if (req[i]) g = 4'h1 << i;
    end
    return g;
  endfunction

  function automatic logic [1:0] onehot_idx(input logic [3:0] oh);
    logic [1:0] n;
    n = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (oh[i]) n = 2'(i);
    end
    return n;
  endfunction

  logic       sel_hit, scan_hit;
  logic [1:0] sel_line, sel_reg, scan_line;
  logic [3:0] lcw_data;

  always_comb begin
    sel_hit   = (line_select_register_i[3:2] == CARD_ID);
    sel_line  = line_select_register_i[1:0];
    sel_reg   = line_control_word_i[LCW_SEL_LSB +: 2];
    lcw_data  = line_control_word_i[LCW_DATA_LSB +: 4];
    scan_hit  = (scan_i[3:2] == CARD_ID);
    scan_line = scan_i[1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Control strobe stretcher and per-line registers

  alc_stb_t         stb_r, stb_nxt;
  logic [4:0]       stb_cnt_r, stb_cnt_nxt;
  logic             stb_prev_r, stb_prev_nxt;
  logic [15:0]      steer_r, steer_nxt;
  logic [3:0][3:0]  primary_r, primary_nxt;
  logic [3:0][3:0]  format_r, format_nxt;
  logic [3:0][3:0]  baud_r, baud_nxt;
  logic [3:0]       maint_r, maint_nxt;
  logic [3:0]       fast_r, fast_nxt;

  always_comb begin
    stb_nxt      = stb_r;
    stb_cnt_nxt  = stb_cnt_r;
    stb_prev_nxt = ctrl_strobe_i;
    steer_nxt    = steer_r;
    primary_nxt  = primary_r;
    format_nxt   = format_r;
    baud_nxt     = baud_r;
    maint_nxt    = maint_r;
    fast_nxt     = fast_r;
    case (stb_r)
      STB_IDLE: begin
        if (ctrl_strobe_i & ~stb_prev_r & sel_hit) begin
          stb_nxt     = STB_HOLD;
          stb_cnt_nxt = 5'(STRETCH_CYC - 1);
          steer_nxt   = 16'h0001 << {sel_line, sel_reg};
          case (sel_reg)
            SEL_PRIMARY: primary_nxt[sel_line] = lcw_data;
            SEL_FORMAT:  format_nxt[sel_line]  = lcw_data;
            SEL_BAUD: begin
              baud_nxt[sel_line] = lcw_data;
              fast_nxt[sel_line] = (lcw_data == FAST_CODE);
            end
            default: maint_nxt[sel_line] = line_control_word_i[LCW_MAINT_BIT];
          endcase
        end
      end
      STB_HOLD: begin
        if (stb_cnt_r == 5'h00) begin
          stb_nxt   = STB_IDLE;
          steer_nxt = 16'h0000;
        end else begin
          stb_cnt_nxt = stb_cnt_r - 5'h01;
        end
      end
      default: begin
        stb_nxt   = STB_IDLE;
        steer_nxt = 16'h0000;
      end
    endcase
    // Format and baud contents survive an init
    if (mux_init_i) begin
      primary_nxt = '0;
      maint_nxt   = '0;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stb_r      <= STB_IDLE;
      stb_cnt_r  <= 5'h00;
      stb_prev_r <= 1'b0;
      steer_r    <= 16'h0000;
      primary_r  <= {4{PRIMARY_RST}};
      format_r   <= {4{FORMAT_RST}};
      baud_r     <= {4{BAUD_RST}};
      maint_r    <= {4{MAINT_RST}};
      fast_r     <= 4'h0;
    end else begin
      stb_r      <= stb_nxt;
      stb_cnt_r  <= stb_cnt_nxt;
      stb_prev_r <= stb_prev_nxt;
      steer_r    <= steer_nxt;
      primary_r  <= primary_nxt;
      format_r   <= format_nxt;
      baud_r     <= baud_nxt;
      maint_r    <= maint_nxt;
      fast_r     <= fast_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive path: intake arbiter, FIFO, receive file and line flags

  logic [3:0]        take_r, take_nxt, take_d_r;
  logic [FIFO_W-1:0] fifo_in, fifo_out;
  logic              fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [1:0]        take_line, out_line;

  always_comb begin
    take_line = onehot_idx(take_r);
    fifo_in   = {take_line,
                 alc_err_code(rx_framing_fault_i[take_line],
                              rx_parity_fault_i[take_line],
                              rx_overrun_i[take_line]),
                 rx_char_i[{take_line, 3'h0} +: 8]};
    take_nxt  = 4'h0;
    // Two idle cycles between takes let the UART drop its available flag
    if (take_r == 4'h0 && take_d_r == 4'h0 && fifo_in_ready) begin
      take_nxt = low_onehot(rx_avail_i);
    end
  end

  alc_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_rx_fifo (
    .mclk_i      (mclk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (|take_r),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out)
  );

  logic [3:0]       match_r, match_nxt, active_r, active_nxt;
  logic [3:0]       pend_r, pend_nxt, rxon_prev_r, rxon_prev_nxt;
  logic [3:0][5:0]  os_cnt_r, os_cnt_nxt;
  logic [2:0]       clrm_cnt_r, clrm_cnt_nxt;
  logic [1:0]       clrm_line_r, clrm_line_nxt;
  logic             rcs_prev_r, rcs_prev_nxt;
  logic [3:0][9:0]  rxfile_r, rxfile_nxt;
  logic [3:0]       rx_on, clear_sync_hit_pulse, clear_rx_pending_pulse, file_load;
  logic             rcs_edge;

  always_comb begin
    out_line       = fifo_out[FIFO_W-1 -: 2];
    // Words for an inactive line are dropped; a full entry stalls the FIFO
    fifo_out_ready = fifo_out_valid & (~pend_r[out_line] | ~active_r[out_line]);
    file_load      = 4'h0;
    if (fifo_out_valid & ~pend_r[out_line] & active_r[out_line]) begin
      file_load[out_line] = 1'b1;
    end
    rcs_prev_nxt  = received_char_strobe_i;
    rcs_edge      = received_char_strobe_i & ~rcs_prev_r & scan_hit;
    clrm_cnt_nxt  = (clrm_cnt_r != 3'h0) ? clrm_cnt_r - 3'h1 : 3'h0;
    clrm_line_nxt = clrm_line_r;
    clear_rx_pending_pulse = 4'h0;
    if (rcs_edge) begin
      if (match_r[scan_line]) begin
        clrm_cnt_nxt  = 3'(CLRM_CYC);
        clrm_line_nxt = scan_line;
      end else begin
        clear_rx_pending_pulse[scan_line] = 1'b1;
      end
    end
    clear_sync_hit_pulse = 4'h0;
    if (clrm_cnt_r != 3'h0) clear_sync_hit_pulse[clrm_line_r] = 1'b1;
    rxfile_nxt    = rxfile_r;
    for (int i = 0; i < 4; i++) begin
      rx_on[i]      = primary_r[i][PRI_RXON_BIT];
      os_cnt_nxt[i] = (os_cnt_r[i] != 6'h00) ? os_cnt_r[i] - 6'h01 : 6'h00;
      if (rx_on[i] & ~rxon_prev_r[i]) os_cnt_nxt[i] = 6'(ONESHOT_CYC);
      match_nxt[i]  = match_r[i] & ~clear_sync_hit_pulse[i] & ~resync_i[i];
      active_nxt[i] = active_r[i] & ~resync_i[i];
      if (os_cnt_r[i] == 6'h01) match_nxt[i] = 1'b1;
      // A held match must not undo a resync of the active flag
      if (match_r[i] & ~resync_i[i]) active_nxt[i] = 1'b1;
      pend_nxt[i] = pend_r[i] & ~clear_rx_pending_pulse[i];
      if (file_load[i]) begin
        pend_nxt[i]   = 1'b1;
        rxfile_nxt[i] = fifo_out[9:0];
      end
      if (!active_r[i]) pend_nxt[i] = 1'b0;
      if (!rx_on[i] || mux_init_i) begin
        match_nxt[i]  = 1'b0;
        active_nxt[i] = 1'b0;
        pend_nxt[i]   = 1'b0;
      end
    end
    // Taken after the loop so the edge detector sees this cycle's level
    rxon_prev_nxt = rx_on;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      take_r      <= 4'h0;
      take_d_r    <= 4'h0;
      match_r     <= 4'h0;
      active_r    <= 4'h0;
      pend_r      <= 4'h0;
      rxon_prev_r <= 4'h0;
      os_cnt_r    <= '0;
      clrm_cnt_r  <= 3'h0;
      clrm_line_r <= 2'h0;
      rcs_prev_r  <= 1'b0;
      rxfile_r    <= '0;
    end else begin
      take_r      <= take_nxt;
      take_d_r    <= take_r;
      match_r     <= match_nxt;
      active_r    <= active_nxt;
      pend_r      <= pend_nxt;
      rxon_prev_r <= rxon_prev_nxt;
      os_cnt_r    <= os_cnt_nxt;
      clrm_cnt_r  <= clrm_cnt_nxt;
      clrm_line_r <= clrm_line_nxt;
      rcs_prev_r  <= rcs_prev_nxt;
      rxfile_r    <= rxfile_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit file and UART loading

  logic [3:0][7:0] txfile_r, txfile_nxt;
  logic [3:0]      txfull_r, txfull_nxt, tx_load_r, tx_load_nxt;
  logic [7:0]      tx_data_r, tx_data_nxt;
  logic            txs_prev_r;
  logic [3:0]      tx_grant;

  always_comb begin
    txfile_nxt  = txfile_r;
    txfull_nxt  = txfull_r;
    tx_data_nxt = tx_data_r;
    tx_load_nxt = 4'h0;
    tx_grant    = 4'h0;
    if (tx_load_r == 4'h0) tx_grant = low_onehot(txfull_r & tx_empty_i);
    if (tx_grant != 4'h0) begin
      tx_load_nxt = tx_grant;
      tx_data_nxt = txfile_r[onehot_idx(tx_grant)];
      txfull_nxt  = txfull_r & ~tx_grant;
    end
    // A host write in the same cycle keeps the entry full
    if (tx_strobe_i & ~txs_prev_r & scan_hit) begin
      txfile_nxt[scan_line] = tx_char_i;
      txfull_nxt[scan_line] = 1'b1;
    end
    if (mux_init_i) txfull_nxt = 4'h0;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      txfile_r   <= '0;
      txfull_r   <= 4'h0;
      tx_load_r  <= 4'h0;
      tx_data_r  <= 8'h00;
      txs_prev_r <= 1'b0;
    end else begin
      txfile_r   <= txfile_nxt;
      txfull_r   <= txfull_nxt;
      tx_load_r  <= tx_load_nxt;
      tx_data_r  <= tx_data_nxt;
      txs_prev_r <= tx_strobe_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-line bit clocks: one tick stream shared by both halves

  for (genvar g = 0; g < 4; g++) begin : g_baud
    alc_baud_gen #(
      .CLK_HZ (CLK_HZ)
    ) u_baud (
      .mclk_i (mclk_i),
      .rstn_i (rstn_i),
      .code_i (baud_r[g]),
      .fast_i (fast_r[g]),
      .tick_o (line_clk_o[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Scanner flags and receive data path

  logic       tx_wait_n_r, rx_flag_n_r, match_det_n_r, rx_bus_oe_r;
  logic [9:0] rx_bus_r;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_wait_n_r   <= 1'b1;
      rx_flag_n_r   <= 1'b1;
      match_det_n_r <= 1'b1;
      rx_bus_r      <= 10'h000;
      rx_bus_oe_r   <= 1'b0;
    end else begin
      tx_wait_n_r   <= ~(scan_hit & scan_tx_i & ~txfull_r[scan_line]);
      rx_flag_n_r   <= ~(scan_hit & ~scan_tx_i & (pend_r[scan_line] | match_r[scan_line]));
      match_det_n_r <= ~(scan_hit & match_r[scan_line]);
      rx_bus_r      <= rxfile_r[scan_line];
      rx_bus_oe_r   <= card_flag_sel_i & data_enable_i;
    end
  end

  assign rx_take_o            = take_r;
  assign tx_load_o            = tx_load_r;
  assign tx_data_o            = tx_data_r;
  assign tx_wait_n_o          = tx_wait_n_r;
  assign rx_flag_n_o          = rx_flag_n_r;
  assign match_det_n_o        = match_det_n_r;
  assign rx_bus_o             = rx_bus_r;
  assign rx_bus_oe_o          = rx_bus_oe_r;
  assign primary_o            = primary_r;
  assign format_o             = format_r;
  assign baud_sel_o           = baud_r;
  assign maint_o              = maint_r;
  assign speed_o              = fast_r;
  assign format_strobe_o      = {steer_r[13], steer_r[9], steer_r[5], steer_r[1]};
  assign baud_select_strobe_o = {steer_r[14], steer_r[10], steer_r[6], steer_r[2]};
endmodule

// File: tb/alc_card_asserts.sv
`timescale 1ns/1ps
module alc_card_asserts
  import alc_pkg::*;
#(
  parameter logic [1:0] CARD_ID = 2'h0
) (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        mux_init_i,
  input  wire logic [3:0]  line_select_register_i,
  input  wire logic [15:0] line_control_word_i,
  input  wire logic        ctrl_strobe_i,
  input  wire logic [3:0]  scan_i,
  input  wire logic        scan_tx_i,
  input  wire logic        card_flag_sel_i,
  input  wire logic        data_enable_i,
  input  wire logic        tx_wait_n_o,
  input  wire logic        rx_flag_n_o,
  input  wire logic        match_det_n_o,
  input  wire logic        rx_bus_oe_o,
  input  wire logic [15:0] primary_o,
  input  wire logic [15:0] format_o,
  input  wire logic [3:0]  format_strobe_o,
  input  wire logic [15:0] baud_sel_o,
  input  wire logic [3:0]  baud_select_strobe_o,
  input  wire logic [3:0]  maint_o,
  input  wire logic [3:0]  speed_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  logic       hit;
  logic       stb;
  logic [1:0] ln;
  logic [1:0] rs;
  assign hit = ctrl_strobe_i && (line_select_register_i[3:2] == CARD_ID);
  assign stb = |{format_strobe_o, baud_select_strobe_o};
  assign ln  = line_select_register_i[1:0];
  assign rs  = line_control_word_i[10:9];
  //////////////////////////////////////////////////////////////
  property p_stb_len;
    $rose(stb) |-> ##19 stb ##1 !stb;
  endproperty
  a_stb_len: assert property (p_stb_len) else $error("strobe width wrong");
  property p_one;
    $onehot0({format_strobe_o, baud_select_strobe_o});
  endproperty
  a_one: assert property (p_one) else $error("strobe not steered to one");
  property p_steer;
    $rose(ctrl_strobe_i) && hit && rs == SEL_FORMAT |=> format_strobe_o == 4'(1 << $past(ln));
  endproperty
  a_steer: assert property (p_steer) else $error("format strobe misrouted");
  property p_pri;
    $rose(ctrl_strobe_i) && hit && rs == SEL_PRIMARY
      |=> 4'(primary_o >> {$past(ln), 2'h0}) == $past(line_control_word_i[14:11]);
  endproperty
  a_pri: assert property (p_pri) else $error("primary not loaded");
  property p_fast;
    $rose(ctrl_strobe_i) && hit && rs == SEL_BAUD && line_control_word_i[14:11] == FAST_CODE
      |=> speed_o[$past(ln)];
  endproperty
  a_fast: assert property (p_fast) else $error("speed flag not set");
  property p_init;
    mux_init_i |=> primary_o == '0 && maint_o == '0 && $stable(format_o) && $stable(baud_sel_o);
  endproperty
  a_init: assert property (p_init) else $error("init clear wrong");
  property p_oe;
    rx_bus_oe_o |-> $past(card_flag_sel_i) && $past(data_enable_i);
  endproperty
  a_oe: assert property (p_oe) else $error("data driven unselected");
  property p_rxside;
    $past(scan_tx_i) |-> rx_flag_n_o;
  endproperty
  a_rxside: assert property (p_rxside) else $error("receiver flag on transmit side");
  property p_txside;
    !$past(scan_tx_i) |-> tx_wait_n_o;
  endproperty
  a_txside: assert property (p_txside) else $error("transmit flag on receive side");
  property p_rxon;
    !match_det_n_o |-> $past(primary_o[{scan_i[1:0], 2'h2}], 2);
  endproperty
  a_rxon: assert property (p_rxon) else $error("match with receiver off");
endmodule

bind alc_card alc_card_asserts #(.CARD_ID(CARD_ID)) u_chk (.*);

// File: tb/alc_uart_model.sv
`timescale 1ns/1ps
module alc_uart_model (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        send_i,
  input  wire logic [10:0] word_i,
  input  wire logic [3:0]  rx_take_i,
  input  wire logic [3:0]  tx_load_i,
  input  wire logic [7:0]  tx_data_i,
  output logic [3:0]       rx_avail_o,
  output logic [31:0]      rx_char_o,
  output logic [2:0]       err_o,
  output logic [3:0]       tx_empty_o,
  output logic [7:0]       got_o
);
  int busy;
  assign tx_empty_o = {3'h7, busy == 0};
  // Only line 0 receives; word_i is {overrun, framing, parity, char}
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_avail_o <= 4'h0;
      rx_char_o  <= 32'h0;
      err_o      <= 3'h0;
      busy       <= 0;
      got_o      <= 8'h00;
    end else begin
      if (send_i) begin
        rx_avail_o[0]  <= 1'b1;
        rx_char_o[7:0] <= word_i[7:0];
        err_o          <= word_i[10:8];
      end else if (rx_take_i[0]) begin
        // Released lines toggle so a late sample cannot pass
        rx_avail_o[0] <= 1'b0;
        rx_char_o     <= ~rx_char_o;
        err_o         <= ~err_o;
      end
      if (tx_load_i[0]) begin
        got_o <= tx_data_i;
        busy  <= 30;
      end else if (busy > 0) begin
        busy <= busy - 1;
      end
    end
  end
endmodule

// File: tb/alc_card_test.sv
`timescale 1ns/1ps
module alc_card_test;
  import alc_pkg::*;
  logic        mclk_i, rstn_i, mux_init_i, ctrl_strobe_i, scan_tx_i, tx_strobe_i, send;
  logic        received_char_strobe_i, card_flag_sel_i, data_enable_i;
  logic        tx_wait_n_o, rx_flag_n_o, match_det_n_o, rx_bus_oe_o;
  logic [3:0]  line_select_register_i, scan_i, resync_i, rx_avail_i, tx_empty_i, rx_take_o, tx_load_o;
  logic [3:0]  maint_o, speed_o, format_strobe_o, baud_select_strobe_o, line_clk;
  logic [15:0] line_control_word_i, primary_o, format_o, baud_sel_o;
  logic [31:0] rx_char_i;
  logic [7:0]  tx_char_i, tx_data_o, got;
  logic [2:0]  err;
  logic [9:0]  rx_bus_o;
  logic [10:0] word;
  int          bad_count, samples_checked;
  logic [10:0] words [4] = '{11'h05A, 11'h1A5, 11'h23C, 11'h7C3};
  logic [1:0]  errs [4]  = '{ERR_NONE, ERR_PARITY, ERR_FRAMING, ERR_OVERRUN};

  alc_card dut (.*, .rx_framing_fault_i({3'h0, err[1]}), .rx_parity_fault_i({3'h0, err[0]}),
    .rx_overrun_i({3'h0, err[2]}), .line_clk_o(line_clk));
  alc_uart_model u_uart (.*, .send_i(send), .word_i(word), .rx_take_i(rx_take_o), .tx_load_i(tx_load_o),
    .tx_data_i(tx_data_o), .rx_avail_o(rx_avail_i), .rx_char_o(rx_char_i), .err_o(err),
    .tx_empty_o(tx_empty_i), .got_o(got));
  //////////////////////////////////////////////////////////////
  task automatic tk(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got_v);
    samples_checked++;
    if (got_v !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, exp, got_v);
    end
  endtask
  // Strobe is held 15 cycles and spaced past the 20-cycle stretch
  task automatic ctrl(input logic [3:0] ls, input logic [1:0] sel, input logic [3:0] d);
    line_select_register_i = ls;
    line_control_word_i = {1'b0, d, sel, 9'h000};
    ctrl_strobe_i = 1'b1;
    tk(15);
    ctrl_strobe_i = 1'b0;
    tk(7);
  endtask
  task automatic rx(input logic [10:0] w);
    word = w;
    send = 1'b1;
    tk(1);
    send = 1'b0;
    tk(10);
  endtask
  task automatic rd();
    received_char_strobe_i = 1'b1;
    tk(3);
    received_char_strobe_i = 1'b0;
    tk(3);
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (4000) @(posedge mclk_i);
    bad_count++;
    print_verdict();
  end
  initial begin
    {rstn_i, mux_init_i, ctrl_strobe_i, scan_tx_i, tx_strobe_i, send} = '0;
    {received_char_strobe_i, card_flag_sel_i, data_enable_i} = '0;
    {line_select_register_i, scan_i, resync_i, line_control_word_i, tx_char_i, word} = '0;
    repeat (5) @(posedge mclk_i);
    #1 rstn_i = 1'b1;
    tk(2);
    ctrl(4'h4, SEL_PRIMARY, 4'hF);
    chk("primary", 16'h0000, primary_o);
    ctrl(4'h1, SEL_FORMAT, 4'hA);
    chk("format", 16'h00A0, format_o);
    ctrl(4'h2, SEL_BAUD, FAST_CODE);
    chk("baud", 16'h0F00, baud_sel_o);
    chk("speed", 16'h0004, speed_o);
    // 38.4K at 16x from 50 MHz is one tick every 81 cycles
    @(posedge line_clk[2]);
    tk(80);
    chk("line_clk", 16'h0, line_clk[2]);
    tk(1);
    chk("line_clk", 16'h1, line_clk[2]);
    ctrl(4'h3, SEL_MAINT, 4'h1);
    chk("maint", 16'h0008, maint_o);
    ctrl(4'h0, SEL_PRIMARY, 4'h4);
    chk("primary", 16'h0004, primary_o);
    chk("match_det_n", 16'h1, match_det_n_o);
    tk(40);
    chk("match_det_n", 16'h0, match_det_n_o);
    chk("rx_flag_n", 16'h0, rx_flag_n_o);
    rd();
    chk("match_det_n", 16'h1, match_det_n_o);
    chk("rx_flag_n", 16'h1, rx_flag_n_o);
    card_flag_sel_i = 1'b1;
    data_enable_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rx(words[i]);
      chk("rx_flag_n", 16'h0, rx_flag_n_o);
      chk("rx_bus", {6'h0, errs[i], words[i][7:0]}, rx_bus_o);
      chk("rx_bus_oe", 16'h1, rx_bus_oe_o);
      rd();
      chk("rx_flag_n", 16'h1, rx_flag_n_o);
    end
    resync_i = 4'h1;
    tk(2);
    resync_i = 4'h0;
    rx(11'h011);
    chk("rx_flag_n", 16'h1, rx_flag_n_o);
    scan_i = 4'h4;
    scan_tx_i = 1'b1;
    tk(2);
    chk("tx_wait_n", 16'h1, tx_wait_n_o);
    scan_i = 4'h0;
    tk(2);
    chk("tx_wait_n", 16'h0, tx_wait_n_o);
    tx_char_i = 8'hC3;
    tx_strobe_i = 1'b1;
    tk(2);
    tx_strobe_i = 1'b0;
    tk(4);
    chk("tx_char", 16'h00C3, got);
    tx_char_i = 8'h3C;
    tx_strobe_i = 1'b1;
    tk(2);
    tx_strobe_i = 1'b0;
    tk(3);
    chk("tx_wait_n", 16'h1, tx_wait_n_o);
    tk(35);
    chk("tx_char", 16'h003C, got);
    mux_init_i = 1'b1;
    tk(1);
    mux_init_i = 1'b0;
    tk(2);
    chk("primary", 16'h0000, primary_o);
    chk("format", 16'h00A0, format_o);
    chk("baud", 16'h0F00, baud_sel_o);
    print_verdict();
  end
endmodule
